/* File: jtgtap_pkg.sv */
// Shared constants, state codes and carriers of the boundary-scan test port
package jtgtap_pkg;

   // ==========================================================
   // Instruction register
   localparam int IR_W = 3;
   localparam logic [IR_W-1:0] INSTR_EXTEST   = 3'h0;
   localparam logic [IR_W-1:0] INSTR_IDCODE   = 3'h1;
   localparam logic [IR_W-1:0] INSTR_SAMPLE_Z = 3'h2;
   localparam logic [IR_W-1:0] INSTR_RSV_LO   = 3'h3; // reserved_code
   localparam logic [IR_W-1:0] INSTR_SAMPLE   = 3'h4;
   localparam logic [IR_W-1:0] INSTR_PRIVATE  = 3'h5;
   localparam logic [IR_W-1:0] INSTR_RSV_HI   = 3'h6; // reserved_code
   localparam logic [IR_W-1:0] INSTR_BYPASS   = 3'h7;
   // Value forced into the low instruction bits at Capture-IR
   localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

   // ==========================================================
   // Data registers
   localparam int          ID_W            = 32;
   localparam logic        BYPASS_CAPTURE  = 1'h0;
   localparam logic        FIXED_CELL_VAL  = 1'h1;
   // Identification code; the value is arbitrary
   localparam logic [31:0] ID_DEFAULT      = 32'h0000_0001;

   // ==========================================================
   // Controller states, coded Gray in the order listed
   typedef enum logic [3:0] {
      TAP_RESET      = 4'h0,
      TAP_IDLE       = 4'h1,
      TAP_SEL_DR     = 4'h3,
      TAP_CAPTURE_DR = 4'h2,
      TAP_SHIFT_DR   = 4'h6,
      TAP_EXIT1_DR   = 4'h7,
      TAP_PAUSE_DR   = 4'h5,
      TAP_EXIT2_DR   = 4'h4,
      TAP_UPDATE_DR  = 4'hC,
      TAP_SEL_IR     = 4'hD,
      TAP_CAPTURE_IR = 4'hF,
      TAP_SHIFT_IR   = 4'hE,
      TAP_EXIT1_IR   = 4'hA,
      TAP_PAUSE_IR   = 4'hB,
      TAP_EXIT2_IR   = 4'h9,
      TAP_UPDATE_IR  = 4'h8
   } jtgtap_state_type;

   // ==========================================================
   // Strobes handed to a data register
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } jtgtap_ctrl_type;

endpackage

/* File: jtgtap_sync.sv */
// Two flip-flop level synchroniser, one lane per bit
`timescale 1ns/100ps
module jtgtap_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   // ==========================================================
   // First stage feeds only the second stage
   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end

endmodule

/* File: jtgtap_bsr.sv */
// Boundary scan register: capture, shift and output update stage
`timescale 1ns/100ps
module jtgtap_bsr #(
   parameter int IN_W  = 16,
   parameter int DQ_W  = 18,
   parameter int FIX_W = 2
) (
   input  wire logic                     tck,
   input  wire logic                     rst,
   input  wire jtgtap_pkg::jtgtap_ctrl_type ctrl,
   input  wire logic [IN_W-1:0]          func_lvl,
   input  wire logic [DQ_W-1:0]          dq_lvl,
   output logic      [DQ_W-1:0]          upd_word,
   output logic                          so
);

   localparam int N = IN_W + DQ_W + FIX_W;

   logic [N-1:0]    cap_vec;
   logic [N-1:0]    sh_reg;
   logic [N-1:0]    sh_next;
   logic [DQ_W-1:0] upd_next;

   // ==========================================================
   // Cells without a pin load their fixed value
   assign cap_vec = {dq_lvl, func_lvl, {FIX_W{jtgtap_pkg::FIXED_CELL_VAL}}};

   // Per-cell capture or shift toward the serial output
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_cell
         logic from_up;
         if (i == N - 1) begin : g_top
            assign from_up = ctrl.tdi;
         end else begin : g_mid
            assign from_up = sh_reg[i+1];
         end
         assign sh_next[i] = ctrl.capture ? cap_vec[i] :
                             ctrl.shift   ? from_up : sh_reg[i];
      end
   endgenerate

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         sh_reg <= '0;
      end else begin
         sh_reg <= sh_next;
      end
   end

   // ==========================================================
   // Output-cell latch moves only on the falling edge in Update-DR
   always_comb begin
      upd_next = ctrl.update ? sh_reg[N-1 -: DQ_W] : upd_word;
   end

   always_ff @(negedge tck or posedge rst) begin
      if (rst) begin
         upd_word <= '0;
      end else begin
         upd_word <= upd_next;
      end
   end

   assign so = sh_reg[0];

endmodule

/* File: jtgtap_top.sv */
// Boundary-scan test access port: controller, instructions and pin muxing
//
// How it works
// - code 111 puts bypass bit in path
// - SAMPLE captures pins, then shifts scan chain
// - pinless cells capture their fixed value
// - code 000 is EXTEST, scan chain selected
// - EXTEST leaves functional inputs reaching core
// - EXTEST drives scan cells from Update-IR fall; pads follow only after the memory-clock crossing
// - EXTEST capture loads pins and fixed cells
// - IDCODE captures ID value, shifts it out
// - IDCODE forced at power-up and reset state
// - code 010 floats outputs, uses scan chain
// - codes 011 and 110 behave as bypass
// - codes read binary, MSB on left
// - instruction register three bits wide
// - Capture-IR loads 01 into low bits
// - new instruction acts only from Update-IR
// - five TMS highs reach reset state
`timescale 1ns/100ps
module jtgtap_top #(
   parameter int          IN_W    = 16,
   parameter int          DQ_W    = 18,
   parameter int          FIX_W   = 2,
   parameter logic [31:0] ID_CODE = jtgtap_pkg::ID_DEFAULT
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            tck,
   input  wire logic            tms,
   input  wire logic            tdi,
   output logic                 tdo,
   output logic                 tdo_oe,
   input  wire logic [IN_W-1:0] func_in,
   input  wire logic [DQ_W-1:0] dq_in,
   input  wire logic [DQ_W-1:0] core_dq_out,
   input  wire logic            core_dq_oe,
   output logic      [DQ_W-1:0] dq_out,
   output logic      [DQ_W-1:0] dq_oe
);

   // ==========================================================
   // Declarations
   jtgtap_pkg::jtgtap_state_type state_reg;
   jtgtap_pkg::jtgtap_state_type state_next;

   logic [jtgtap_pkg::IR_W-1:0] ir_sh_reg;
   logic [jtgtap_pkg::IR_W-1:0] ir_sh_next;
   logic [jtgtap_pkg::IR_W-1:0] instr_reg;
   logic [jtgtap_pkg::IR_W-1:0] instr_next;
   logic                        byp_reg;
   logic                        byp_next;
   logic [jtgtap_pkg::ID_W-1:0] id_reg;
   logic [jtgtap_pkg::ID_W-1:0] id_next;
   logic                        tdo_next;
   logic                        tdo_oe_next;
   logic                        tog_reg;
   logic                        tog_next;

   logic                        sel_bsr;
   logic                        sel_id;
   // Pad modes kept in flops, so the crossing never sees a decode glitch
   logic                        extest_reg;
   logic                        extest_next;
   logic                        highz_reg;
   logic                        highz_next;
   logic                        bsr_so;
   logic [DQ_W-1:0]             upd_word;
   logic [IN_W-1:0]             func_lvl;
   logic [DQ_W-1:0]             dq_lvl;
   jtgtap_pkg::jtgtap_ctrl_type bsr_ctrl;

   logic [2:0]                  xs;
   logic                        tog_seen_reg;
   logic                        tog_seen_next;
   logic [DQ_W-1:0]             word_reg;
   logic [DQ_W-1:0]             word_next;
   logic [DQ_W-1:0]             dq_out_next;
   logic [DQ_W-1:0]             dq_oe_next;

   // ==========================================================
   // Controller state walk; TMS high from any state reaches reset in five edges
   always_comb begin
      unique case (state_reg)
         jtgtap_pkg::TAP_RESET:      state_next = tms ? jtgtap_pkg::TAP_RESET :
                                                        jtgtap_pkg::TAP_IDLE;
         jtgtap_pkg::TAP_IDLE:       state_next = tms ? jtgtap_pkg::TAP_SEL_DR :
                                                        jtgtap_pkg::TAP_IDLE;
         jtgtap_pkg::TAP_SEL_DR:     state_next = tms ? jtgtap_pkg::TAP_SEL_IR :
                                                        jtgtap_pkg::TAP_CAPTURE_DR;
         jtgtap_pkg::TAP_CAPTURE_DR: state_next = tms ? jtgtap_pkg::TAP_EXIT1_DR :
                                                        jtgtap_pkg::TAP_SHIFT_DR;
         jtgtap_pkg::TAP_SHIFT_DR:   state_next = tms ? jtgtap_pkg::TAP_EXIT1_DR :
                                                        jtgtap_pkg::TAP_SHIFT_DR;
         jtgtap_pkg::TAP_EXIT1_DR:   state_next = tms ? jtgtap_pkg::TAP_UPDATE_DR :
                                                        jtgtap_pkg::TAP_PAUSE_DR;
         jtgtap_pkg::TAP_PAUSE_DR:   state_next = tms ? jtgtap_pkg::TAP_EXIT2_DR :
                                                        jtgtap_pkg::TAP_PAUSE_DR;
         jtgtap_pkg::TAP_EXIT2_DR:   state_next = tms ? jtgtap_pkg::TAP_UPDATE_DR :
                                                        jtgtap_pkg::TAP_SHIFT_DR;
         jtgtap_pkg::TAP_UPDATE_DR:  state_next = tms ? jtgtap_pkg::TAP_SEL_DR :
                                                        jtgtap_pkg::TAP_IDLE;
         jtgtap_pkg::TAP_SEL_IR:     state_next = tms ? jtgtap_pkg::TAP_RESET :
                                                        jtgtap_pkg::TAP_CAPTURE_IR;
         jtgtap_pkg::TAP_CAPTURE_IR: state_next = tms ? jtgtap_pkg::TAP_EXIT1_IR :
                                                        jtgtap_pkg::TAP_SHIFT_IR;
         jtgtap_pkg::TAP_SHIFT_IR:   state_next = tms ? jtgtap_pkg::TAP_EXIT1_IR :
                                                        jtgtap_pkg::TAP_SHIFT_IR;
         jtgtap_pkg::TAP_EXIT1_IR:   state_next = tms ? jtgtap_pkg::TAP_UPDATE_IR :
                                                        jtgtap_pkg::TAP_PAUSE_IR;
         jtgtap_pkg::TAP_PAUSE_IR:   state_next = tms ? jtgtap_pkg::TAP_EXIT2_IR :
                                                        jtgtap_pkg::TAP_PAUSE_IR;
         jtgtap_pkg::TAP_EXIT2_IR:   state_next = tms ? jtgtap_pkg::TAP_UPDATE_IR :
                                                        jtgtap_pkg::TAP_SHIFT_IR;
         jtgtap_pkg::TAP_UPDATE_IR:  state_next = tms ? jtgtap_pkg::TAP_SEL_DR :
                                                        jtgtap_pkg::TAP_IDLE;
      endcase
   end

   // ==========================================================
   // Instruction decode; codes compared as binary, MSB leftmost
   always_comb begin
      sel_bsr   = 1'b0;
      sel_id    = 1'b0;
      // Pad modes are decoded apart, from the incoming instruction, in the falling stage
      unique case (instr_reg)
         jtgtap_pkg::INSTR_EXTEST:   sel_bsr = 1'b1;
         jtgtap_pkg::INSTR_IDCODE:   sel_id = 1'b1;
         jtgtap_pkg::INSTR_SAMPLE_Z: sel_bsr = 1'b1;
         jtgtap_pkg::INSTR_SAMPLE:   sel_bsr = 1'b1;
         // Everything else lands on the bypass bit, touching nothing in the memory
         jtgtap_pkg::INSTR_RSV_LO,
         jtgtap_pkg::INSTR_RSV_HI,
         jtgtap_pkg::INSTR_PRIVATE,
         jtgtap_pkg::INSTR_BYPASS:   sel_bsr = 1'b0;
      endcase
   end

   // ==========================================================
   // Rising-edge serial registers: instruction shifter, bypass, identification
   always_comb begin
      ir_sh_next = ir_sh_reg;
      byp_next   = byp_reg;
      id_next    = id_reg;
      if (state_reg == jtgtap_pkg::TAP_CAPTURE_IR) begin
         ir_sh_next = jtgtap_pkg::IR_CAPTURE_VAL;
      end else if (state_reg == jtgtap_pkg::TAP_SHIFT_IR) begin
         ir_sh_next = {tdi, ir_sh_reg[jtgtap_pkg::IR_W-1:1]};
      end
      if (state_reg == jtgtap_pkg::TAP_CAPTURE_DR) begin
         byp_next = jtgtap_pkg::BYPASS_CAPTURE;
         if (sel_id) begin
            id_next = ID_CODE;
         end
      end else if (state_reg == jtgtap_pkg::TAP_SHIFT_DR) begin
         byp_next = tdi;
         if (sel_id) begin
            id_next = {tdi, id_reg[jtgtap_pkg::ID_W-1:1]};         // LSB leaves first
         end
      end
   end

   // Power-up lands in reset with the identification instruction loaded
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         state_reg <= jtgtap_pkg::TAP_RESET;
         ir_sh_reg <= jtgtap_pkg::IR_CAPTURE_VAL;
         byp_reg   <= jtgtap_pkg::BYPASS_CAPTURE;
         id_reg    <= '0;
      end else begin
         state_reg <= state_next;
         ir_sh_reg <= ir_sh_next;
         byp_reg   <= byp_next;
         id_reg    <= id_next;
      end
   end

   // ==========================================================
   // Falling-edge stage: active instruction, serial output, update toggle
   always_comb begin
      instr_next  = instr_reg;
      tog_next    = tog_reg;
      tdo_next    = tdo;
      tdo_oe_next = 1'b0;
      if (state_reg == jtgtap_pkg::TAP_RESET) begin
         instr_next = jtgtap_pkg::INSTR_IDCODE;
      end else if (state_reg == jtgtap_pkg::TAP_UPDATE_IR) begin
         instr_next = ir_sh_reg;
      end
      // Pad modes follow the instruction that lands at this same edge
      extest_next = (instr_next == jtgtap_pkg::INSTR_EXTEST);
      highz_next  = (instr_next == jtgtap_pkg::INSTR_SAMPLE_Z);
      // Only a chain instruction refreshes the pad word; ID and bypass scans leave it
      if (sel_bsr && (state_reg == jtgtap_pkg::TAP_UPDATE_DR)) begin
         tog_next = ~tog_reg;
      end
      if (state_reg == jtgtap_pkg::TAP_SHIFT_IR) begin
         tdo_next    = ir_sh_reg[0];
         tdo_oe_next = 1'b1;
      end else if (state_reg == jtgtap_pkg::TAP_SHIFT_DR) begin
         tdo_next    = sel_bsr ? bsr_so : (sel_id ? id_reg[0] : byp_reg);
         tdo_oe_next = 1'b1;
      end
   end

   // Instruction, pad modes and serial output all move on the falling edge
   always_ff @(negedge tck or posedge rst) begin
      if (rst) begin
         instr_reg <= jtgtap_pkg::INSTR_IDCODE;
         extest_reg <= 1'b0;
         highz_reg  <= 1'b0;
         tog_reg   <= 1'b0;
         tdo       <= 1'b0;
         tdo_oe    <= 1'b0;
      end else begin
         instr_reg <= instr_next;
         extest_reg <= extest_next;
         highz_reg  <= highz_next;
         tog_reg   <= tog_next;
         tdo       <= tdo_next;
         tdo_oe    <= tdo_oe_next;
      end
   end

   // ==========================================================
   // Pin levels reach the capture cells only after two test-clock flops
   jtgtap_sync #(
      .W (IN_W + DQ_W)
   ) u_pin_sync (
      .clk (tck),
      .rst (rst),
      .d   ({dq_in, func_in}),
      .q   ({dq_lvl, func_lvl})
   );

   // Any capture of the scan chain samples the ring, whichever chain instruction
   assign bsr_ctrl.capture = sel_bsr && (state_reg == jtgtap_pkg::TAP_CAPTURE_DR);
   assign bsr_ctrl.shift   = sel_bsr && (state_reg == jtgtap_pkg::TAP_SHIFT_DR);
   assign bsr_ctrl.update  = sel_bsr && (state_reg == jtgtap_pkg::TAP_UPDATE_DR);
   assign bsr_ctrl.tdi     = tdi;

   jtgtap_bsr #(
      .IN_W  (IN_W),
      .DQ_W  (DQ_W),
      .FIX_W (FIX_W)
   ) u_bsr (
      .tck      (tck),
      .rst      (rst),
      .ctrl     (bsr_ctrl),
      .func_lvl (func_lvl),
      .dq_lvl   (dq_lvl),
      .upd_word (upd_word),
      .so       (bsr_so)
   );

   // ==========================================================
   // Crossing into the memory clock: two levels and the update toggle
   // A mode change may land one memory clock apart per lane; SAMPLE-Z wins a tie
   jtgtap_sync #(
      .W (3)
   ) u_ctl_sync (
      .clk (clk),
      .rst (rst),
      .d   ({tog_reg, highz_reg, extest_reg}),
      .q   (xs)
   );

   // The word is copied only after its toggle is seen, by then long settled
   // Updates closer than three memory clocks apart may lose the earlier word
   always_comb begin
      tog_seen_next = xs[2];
      word_next     = (xs[2] != tog_seen_reg) ? upd_word : word_reg;
      dq_out_next   = core_dq_out;
      dq_oe_next    = {DQ_W{core_dq_oe}};
      if (xs[1]) begin
         dq_oe_next  = '0;
      end else if (xs[0]) begin
         dq_out_next = word_next;
         dq_oe_next  = '1;
      end
   end

   // Only drivers are steered; functional inputs go to the core untouched
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tog_seen_reg <= 1'b0;
         word_reg     <= '0;
         dq_out       <= '0;
         dq_oe        <= '0;
      end else begin
         tog_seen_reg <= tog_seen_next;
         word_reg     <= word_next;
         dq_out       <= dq_out_next;
         dq_oe        <= dq_oe_next;
      end
   end

endmodule

/* File: jtgtap_ctl.sv */
// Model of the external test controller that walks the port over tck
`timescale 1ns/100ps
module jtgtap_ctl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   // ==========================================================
   // Link lines
   // Clock stands still low between frames; idle lines sit at one like a pull-up
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end

   // ==========================================================
   // Link cycles
   // One 6 ns period; tdo taken at the rising edge, a floating line reads z
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #3 tck = 1'h1;
      o = tdo_oe ? tdo : 1'hz;
      #3 tck = 1'h0;
   endtask

   // Reset path needs no pin: five highs, then one low to park in idle
   task automatic reset5;
      logic o;
      repeat (5) step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
   endtask

   // Idle cycles keep the link clock running while pads settle
   task automatic idle(input int n);
      logic o;
      repeat (n) step(1'h0, 1'h1, o);
   endtask

   // Instruction load from idle; code goes out LSB first
   task automatic ir_scan(input logic [2:0] code, output logic [2:0] cap);
      logic o;
      step(1'h1, 1'h1, o);
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      step(1'h0, 1'h1, o);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, code[i], cap[i]);
      end
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
   endtask

   // Data scan of n bits from idle, first bit seen is bit 0
   task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
      logic o;
      dout = 64'h0;
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      step(1'h0, 1'h1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
   endtask
endmodule

/* File: jtgtap_chk.sv */
// Port-level assertions for the boundary-scan test port
`timescale 1ns/100ps
module jtgtap_chk #(
   parameter int          IN_W    = 16,
   parameter int          DQ_W    = 18,
   parameter int          FIX_W   = 2,
   parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            tck,
   input wire logic            tms,
   input wire logic            tdi,
   input wire logic            tdo,
   input wire logic            tdo_oe,
   input wire logic [IN_W-1:0] func_in,
   input wire logic [DQ_W-1:0] dq_in,
   input wire logic [DQ_W-1:0] core_dq_out,
   input wire logic            core_dq_oe,
   input wire logic [DQ_W-1:0] dq_out,
   input wire logic [DQ_W-1:0] dq_oe
);
   // ==========================================================
   // Link side
   // Five highs then a low pin the controller in idle, so later walks are known
   sequence s_tlr_idle;
      tms [*5] ##1 !tms;
   endsequence

   a_oe_off_exit: assert property (@(posedge tck) disable iff (rst) tms |=> !tdo_oe)
      else $error("tdo driven after a high tms");
   a_oe_two_lows: assert property (@(posedge tck) disable iff (rst)
      tdo_oe |-> !$past(tms) && (!$past(tms, 2) || !$past(tms, 3)))
      else $error("tdo driven without reaching a shift state");
   a_tlr_stays_quiet: assert property (@(posedge tck) disable iff (rst)
      s_tlr_idle ##1 !tms |=> !tdo_oe)
      else $error("tdo driven while idling after reset walk");
   a_ir_cap_one: assert property (@(posedge tck) disable iff (rst)
      s_tlr_idle ##1 tms ##1 tms ##1 !tms ##1 !tms |=> tdo_oe && tdo)
      else $error("instruction capture bit 0 not one");
   a_ir_cap_zero: assert property (@(posedge tck) disable iff (rst)
      s_tlr_idle ##1 tms ##1 tms ##1 !tms ##1 !tms ##1 !tms |=> tdo_oe && !tdo)
      else $error("instruction capture bit 1 not zero");
   a_id_after_reset: assert property (@(posedge tck) disable iff (rst)
      s_tlr_idle ##1 tms ##1 !tms ##1 !tms |=> tdo_oe && (tdo == ID_CODE[0]))
      else $error("first data bit after reset walk is not the id bit");
   a_samplez_float: assert property (@(posedge tck) disable iff (rst)
      s_tlr_idle ##1 tms ##1 tms ##1 !tms ##1 !tms ##1 (!tms && !tdi) ##1 (!tms && tdi)
      ##1 (tms && !tdi) ##1 tms |-> ##[1:100] (dq_oe == '0))
      else $error("pads still driven after loading code 010");

   // ==========================================================
   // Pad side
   // Pad enables move as one word in every mode
   a_oe_one_word: assert property (@(posedge clk) disable iff (rst)
      (dq_oe == '0) || (dq_oe == '1))
      else $error("pad enables split across the word");

   c_shift: cover property (@(posedge tck) disable iff (rst) tdo_oe);
   c_drive_all: cover property (@(posedge clk) disable iff (rst) dq_oe == '1 && !core_dq_oe);
   c_float_all: cover property (@(posedge clk) disable iff (rst) dq_oe == '0 && core_dq_oe);
endmodule

bind jtgtap_top jtgtap_chk #(.IN_W(IN_W), .DQ_W(DQ_W), .ID_CODE(ID_CODE)) chk (
   .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
   .func_in(func_in), .dq_in(dq_in), .core_dq_out(core_dq_out), .core_dq_oe(core_dq_oe),
   .dq_out(dq_out), .dq_oe(dq_oe));

/* File: jtgtap_top_test.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module jtgtap_top_test;
   localparam int IN_W  = 4;
   localparam int DQ_W  = 4;
   localparam int FIX_W = 2;
   localparam int CH_W  = FIX_W + IN_W + DQ_W;
   localparam logic [FIX_W-1:0] FIXV = {FIX_W{jtgtap_pkg::FIXED_CELL_VAL}};

   logic            clk;
   logic            rst;
   logic [IN_W-1:0] func_in;
   logic [DQ_W-1:0] dq_in;
   logic [DQ_W-1:0] core_dq_out;
   logic            core_dq_oe;
   wire logic       tck;
   wire logic       tms;
   wire logic       tdi;
   wire logic       tdo;
   wire logic       tdo_oe;
   wire logic [DQ_W-1:0] dq_out;
   wire logic [DQ_W-1:0] dq_oe;
   int              err_total;
   int              n_checks;

   // ==========================================================
   // Design and far side
   jtgtap_top #(.IN_W(IN_W), .DQ_W(DQ_W)) uut (
      .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .func_in(func_in), .dq_in(dq_in), .core_dq_out(core_dq_out), .core_dq_oe(core_dq_oe),
      .dq_out(dq_out), .dq_oe(dq_oe));
   jtgtap_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   // ==========================================================
   // Reporting
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Pins change at the memory clock's falling edge, then settle through two tck flops
   task automatic set_pins(input logic [IN_W-1:0] f, input logic [DQ_W-1:0] q);
      @(negedge clk);
      func_in = f;
      dq_in = q;
      ctl.idle(3);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_idcode;
      logic [63:0] d;
      logic [2:0]  c;
      ctl.idle(1);
      ctl.dr_scan(32, 64'h0, d);
      check("id after power-up", d[31:0], jtgtap_pkg::ID_DEFAULT);
      ctl.ir_scan(jtgtap_pkg::INSTR_BYPASS, c);
      check("ir capture", c, jtgtap_pkg::IR_CAPTURE_VAL);
      ctl.reset5();
      ctl.dr_scan(32, 64'h0, d);
      check("id after tms reset", d[31:0], jtgtap_pkg::ID_DEFAULT);
   endtask

   // Every code that falls back to the one-bit path, pads left to the core
   task automatic t_bypass;
      logic [2:0]  codes [4];
      logic [63:0] d;
      logic [2:0]  c;
      codes = '{jtgtap_pkg::INSTR_RSV_LO, jtgtap_pkg::INSTR_PRIVATE,
                jtgtap_pkg::INSTR_RSV_HI, jtgtap_pkg::INSTR_BYPASS};
      for (int i = 0; i < 4; i++) begin
         ctl.ir_scan(codes[i], c);
         @(negedge clk);
         core_dq_out = DQ_W'(4'h6 ^ i);
         core_dq_oe = i[0];
         ctl.idle(80);
         check("bypass pad data", dq_out, core_dq_out);
         check("bypass pad oe", dq_oe, {DQ_W{core_dq_oe}});
         ctl.dr_scan(4, 64'hB, d);
         check("bypass path", d[3:0], {3'h3, jtgtap_pkg::BYPASS_CAPTURE});
      end
   endtask

   // Sample the ring, preload 4'hC for the drive that follows
   task automatic t_sample;
      logic [63:0] d;
      logic [2:0]  c;
      set_pins(4'hA, 4'h5);
      ctl.ir_scan(jtgtap_pkg::INSTR_SAMPLE, c);
      ctl.dr_scan(CH_W, {4'hC, 6'h0}, d);
      check("sample chain", d[CH_W-1:0], {dq_in, func_in, FIXV});
   endtask

   task automatic t_extest;
      logic [63:0] d;
      logic [2:0]  c;
      ctl.ir_scan(jtgtap_pkg::INSTR_EXTEST, c);
      ctl.idle(80);
      check("extest oe", dq_oe, {DQ_W{1'h1}});
      check("extest preload", dq_out, 4'hC);
      set_pins(4'h3, 4'hE);
      ctl.dr_scan(CH_W, {4'h9, 6'h0}, d);
      check("extest chain", d[CH_W-1:0], {dq_in, func_in, FIXV});
      ctl.idle(80);
      check("extest update", dq_out, 4'h9);
   endtask

   task automatic t_sample_z;
      logic [63:0] d;
      logic [2:0]  c;
      ctl.reset5();
      ctl.ir_scan(jtgtap_pkg::INSTR_SAMPLE_Z, c);
      check("ir capture z", c, jtgtap_pkg::IR_CAPTURE_VAL);
      ctl.idle(80);
      check("sample-z oe", dq_oe, {DQ_W{1'h0}});
      set_pins(4'h6, 4'h9);
      ctl.dr_scan(CH_W, 64'h0, d);
      check("sample-z chain", d[CH_W-1:0], {dq_in, func_in, FIXV});
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Whole run needs well under 100 us; a hang is cut off at 400 us
   initial begin
      #400000;
      err_total++;
      final_report();
   end

   initial begin
      logic b;
      err_total = 0;
      n_checks = 0;
      rst = 1'h1;
      func_in = 4'h0;
      dq_in = 4'h0;
      core_dq_out = 4'h0;
      core_dq_oe = 1'h0;
      @(posedge clk);
      ctl.step(1'h1, 1'h1, b);
      @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_sample_z();
      final_report();
   end
endmodule
